// ==== hdl/opcode_decoder.v ====
// Purpose: Decodes accumulator, auxiliary, page, status, multiplicand,
//          multiply, normalize, OR-immediate and product transfer opcodes
// Assumes: Fetch words arrive synchronous to REF_CLK with valid and ready
// Notes: Two-word forms are issued only once their constant word is in
//
// Summary of operation
// - Upper byte b9 loads accumulator with low-byte constant; zero clears it; 1/1.
// - Upper byte 6a zeroes low accumulator and loads high half; 1/1.
// - Upper byte 69 zeroes accumulator, loads low half unsigned; 1/1.
// - Upper byte 6b loads accumulator shifted by multiplicand register; 1/1.
// - Nibble b then 0 plus select loads aux register from byte; 1/2.
// - Word bf08 to bf0f plus constant word loads aux register; 2/2.
// - Prefix 1011110 loads page pointer with nine-bit immediate; 1/2.
// - Upper bytes 0e and 0f load status register zero or one; 1/2.
// - Upper byte 70 loads multiplicand and adds previous product; 1/1.
// - Upper byte 72 loads multiplicand, accumulates, moves data word; 1/1.
// - Upper byte 71 loads multiplicand, product goes to accumulator; 1/1.
// - Upper byte 74 loads multiplicand, subtracts previous product; 1/1.
// - Upper bytes a2 and a3 plus constant word multiply-accumulate; 2/3.
// - Word 8b88 to 8b8f loads the aux register pointer; 1/1.
// - Upper byte 54 multiplies by data; prefix 110 multiplies by 13-bit constant.
// - Upper byte 50 multiplies and adds previous product; 1/1.
// - Upper byte 51 multiplies and subtracts previous product; 1/1.
// - Upper byte a0 normalizes the accumulator; 1/1.
// - Word bfcX plus constant ORs shifted constant into accumulator; 2/2.
// - Word be82 plus constant ORs constant shifted by 16; 2/2.
// - Word be03 copies product register into accumulator; 1/1.
`include "opcode_decoder_defines.vh"
`default_nettype none

module opcode_decoder #(
    parameter WORD_WIDTH = 16
) (
    input wire REF_CLK,
    input wire RST,
    input wire FETCH_VALID,
    input wire [WORD_WIDTH-1:0] FETCH_WORD,
    output wire FETCH_READY,
    input wire EXEC_READY,
    output wire DEC_VALID,
    output reg [4:0] DEC_OP,
    output reg [1:0] DEC_WORDS,
    output reg [1:0] DEC_CYCLES,
    output reg [7:0] DEC_ADDR_FIELD,
    output reg [WORD_WIDTH-1:0] DEC_IMM,
    output reg [2:0] DEC_AUX_SEL,
    output reg [4:0] DEC_SHIFT,
    output reg DEC_ZERO_ACC,
    output reg DEC_UNKNOWN
);

    localparam ST_OPCODE = 2'b01;
    localparam ST_OPERAND = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg out_full;
    wire accept;
    wire [WORD_WIDTH-1:0] held_word;
    wire [WORD_WIDTH-1:0] cls_word;
    wire in_operand;

    // Classification results of cls_word
    reg [4:0] cls_op;
    reg [1:0] cls_words;
    reg [1:0] cls_cycles;
    reg [WORD_WIDTH-1:0] cls_imm;
    reg [2:0] cls_aux;
    reg [4:0] cls_shift;
    reg cls_zero;
    reg cls_known;

    assign in_operand = (state == ST_OPERAND);
    // Slot frees as the pipeline takes the held decode
    assign FETCH_READY = !out_full || EXEC_READY;
    assign accept = FETCH_VALID && FETCH_READY;
    assign DEC_VALID = out_full;
    // Operand cycle decodes the held first word, not the constant
    assign cls_word = in_operand ? held_word : FETCH_WORD;

    word_hold #(
        .WIDTH(WORD_WIDTH)
    ) u_first_word (
        .clk(REF_CLK),
        .rst(RST),
        .load(accept && !in_operand),
        .din(FETCH_WORD),
        .dout(held_word)
    );

    always @* begin
        cls_op = `OP_NONE;
        cls_words = `WORDS_ONE;
        cls_cycles = `CYCLES_ONE;
        cls_imm = {WORD_WIDTH{1'b0}};
        cls_aux = 3'h0;
        cls_shift = 5'h00;
        cls_zero = 1'b0;
        cls_known = 1'b1;
        // Whole-word forms first so that wider prefixes cannot shadow them
        if ((cls_word & `MASK_FULL) == `PAT_PRODUCT_TO_ACC) begin
            cls_op = `OP_PRODUCT_TO_ACC;
        end else if ((cls_word & `MASK_FULL) == `PAT_OR_IMM_SHIFT16) begin
            cls_op = `OP_OR_IMM_SHIFT16;
            cls_words = `WORDS_TWO;
            cls_cycles = `CYCLES_TWO;
            cls_shift = `SHIFT_OF_16;
        end else if ((cls_word & `MASK_UPPER_12) == `PAT_OR_IMM_SHIFT) begin
            cls_op = `OP_OR_IMM_SHIFT;
            cls_words = `WORDS_TWO;
            cls_cycles = `CYCLES_TWO;
            cls_shift = {1'b0, cls_word[`FLD_SHIFT_MSB:0]};
        end else if ((cls_word & `MASK_UPPER_13) == `PAT_LOAD_AUX_LONG) begin
            cls_op = `OP_LOAD_AUX_REG_LONG;
            cls_words = `WORDS_TWO;
            cls_cycles = `CYCLES_TWO;
            cls_aux = cls_word[`FLD_AUXP_MSB:0];
        end else if ((cls_word & `MASK_UPPER_13) == `PAT_LOAD_AUX_PTR) begin
            cls_op = `OP_LOAD_AUX_PTR;
            cls_aux = cls_word[`FLD_AUXP_MSB:0];
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_ACC_LOW_SHORT) begin
            cls_op = `OP_LOAD_ACC_LOW_SHORT;
            cls_imm = {{(WORD_WIDTH-8){1'b0}}, cls_word[`FLD_ADDR_MSB:0]};
            cls_zero = (cls_word[`FLD_ADDR_MSB:0] == `ZERO_BYTE);
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_ZERO_LOW_LOAD_HIGH) begin
            cls_op = `OP_ZERO_LOW_LOAD_HIGH;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_ZERO_LOAD_LOW) begin
            cls_op = `OP_ZERO_LOAD_LOW_NO_SIGN;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_ACC_SHIFT_MULT) begin
            cls_op = `OP_LOAD_ACC_SHIFT_BY_MULT;
        end else if ((cls_word & `MASK_UPPER_5) == `PAT_LOAD_AUX_SHORT) begin
            cls_op = `OP_LOAD_AUX_REG_SHORT;
            cls_cycles = `CYCLES_TWO;
            cls_aux = cls_word[`FLD_AUX_MSB:`FLD_AUX_LSB];
            cls_imm = {{(WORD_WIDTH-8){1'b0}}, cls_word[`FLD_ADDR_MSB:0]};
        end else if ((cls_word & `MASK_UPPER_7) == `PAT_LOAD_PAGE_IMM) begin
            cls_op = `OP_LOAD_PAGE_PTR_IMM;
            cls_cycles = `CYCLES_TWO;
            cls_imm = {{(WORD_WIDTH-9){1'b0}}, cls_word[`FLD_PAGE_MSB:0]};
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_STATUS_ZERO) begin
            cls_op = `OP_LOAD_STATUS_ZERO;
            cls_cycles = `CYCLES_TWO;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_STATUS_ONE) begin
            cls_op = `OP_LOAD_STATUS_ONE;
            cls_cycles = `CYCLES_TWO;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_MULT_ACC) begin
            cls_op = `OP_LOAD_MULT_AND_ACCUMULATE;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_MULT_ACC_MOVE) begin
            cls_op = `OP_LOAD_MULT_ACC_MOVE;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_MULT_PRODUCT) begin
            cls_op = `OP_LOAD_MULT_AND_PRODUCT;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_LOAD_MULT_SUBTRACT) begin
            cls_op = `OP_LOAD_MULT_AND_SUBTRACT;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_MULT_ACC) begin
            cls_op = `OP_MULTIPLY_ACCUMULATE;
            cls_words = `WORDS_TWO;
            cls_cycles = `CYCLES_THREE;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_MULT_ACC_MOVE) begin
            cls_op = `OP_MULTIPLY_ACCUMULATE_MOVE;
            cls_words = `WORDS_TWO;
            cls_cycles = `CYCLES_THREE;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_MULTIPLY_DATA) begin
            cls_op = `OP_MULTIPLY_DATA;
        end else if ((cls_word & `MASK_UPPER_3) == `PAT_MULTIPLY_IMM) begin
            cls_op = `OP_MULTIPLY_IMM;
            cls_imm = {{(WORD_WIDTH-13){1'b0}}, cls_word[`FLD_MPYK_MSB:0]};
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_MULTIPLY_ADD_PREV) begin
            cls_op = `OP_MULTIPLY_ADD_PREV;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_MULTIPLY_SUB_PREV) begin
            cls_op = `OP_MULTIPLY_SUB_PREV;
        end else if ((cls_word & `MASK_UPPER_BYTE) == `PAT_NORMALIZE_ACC) begin
            cls_op = `OP_NORMALIZE_ACC;
        end else begin
            // Outside this decoder's slice; reported, not swallowed
            cls_known = 1'b0;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_OPCODE: begin
                // Hold off issue until the constant word arrives
                if (accept && cls_known && (cls_words == `WORDS_TWO)) begin
                    next_state = ST_OPERAND;
                end
            end
            ST_OPERAND: begin
                if (accept) begin
                    next_state = ST_OPCODE;
                end
            end
            default: begin
                next_state = ST_OPCODE;
            end
        endcase
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= ST_OPCODE;
        end else begin
            state <= next_state;
        end
    end

    wire issue_single;
    wire issue_double;
    assign issue_single = accept && !in_operand &&
        !(cls_known && (cls_words == `WORDS_TWO));
    assign issue_double = accept && in_operand;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            out_full <= 1'b0;
            DEC_OP <= `OP_NONE;
            DEC_WORDS <= 2'h0;
            DEC_CYCLES <= 2'h0;
            DEC_ADDR_FIELD <= 8'h00;
            DEC_IMM <= {WORD_WIDTH{1'b0}};
            DEC_AUX_SEL <= 3'h0;
            DEC_SHIFT <= 5'h00;
            DEC_ZERO_ACC <= 1'b0;
            DEC_UNKNOWN <= 1'b0;
        end else begin
            if (issue_single || issue_double) begin
                out_full <= 1'b1;
                DEC_OP <= cls_op;
                DEC_WORDS <= cls_words;
                DEC_CYCLES <= cls_cycles;
                DEC_ADDR_FIELD <= cls_word[`FLD_ADDR_MSB:0];
                // Second word is the constant for all two-word forms
                DEC_IMM <= issue_double ? FETCH_WORD : cls_imm;
                DEC_AUX_SEL <= cls_aux;
                DEC_SHIFT <= cls_shift;
                DEC_ZERO_ACC <= cls_zero;
                DEC_UNKNOWN <= !cls_known;
            end else if (EXEC_READY) begin
                out_full <= 1'b0;
            end
        end
    end

endmodule // opcode_decoder

`default_nettype wire

// ==== hdl/word_hold.v ====
// Purpose: Holds the first word of a two-word instruction
// Assumes: Load is a one-cycle enable in the REF_CLK domain
// Notes: Clears to zero under reset
`default_nettype none

module word_hold #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= {WIDTH{1'b0}};
        end else if (load) begin
            dout <= din;
        end
    end

endmodule // word_hold

`default_nettype wire

// ==== pkg/opcode_decoder_defines.vh ====
// Purpose: Shared constants of the load and multiply opcode decoder
// Assumes: Included by bare name from the design files
// Notes: Patterns are mask and match pairs on the first instruction word
`ifndef OPCODE_DECODER_DEFINES_VH
`define OPCODE_DECODER_DEFINES_VH

// Operation identifiers presented to the execution pipeline
`define OP_NONE                      5'h00
`define OP_LOAD_ACC_LOW_SHORT        5'h01
`define OP_ZERO_LOW_LOAD_HIGH        5'h02
`define OP_ZERO_LOAD_LOW_NO_SIGN     5'h03
`define OP_LOAD_ACC_SHIFT_BY_MULT    5'h04
`define OP_LOAD_AUX_REG_SHORT        5'h05
`define OP_LOAD_AUX_REG_LONG         5'h06
`define OP_LOAD_PAGE_PTR_IMM         5'h07
`define OP_LOAD_STATUS_ZERO          5'h08
`define OP_LOAD_STATUS_ONE           5'h09
`define OP_LOAD_MULT_AND_ACCUMULATE  5'h0a
`define OP_LOAD_MULT_ACC_MOVE        5'h0b
`define OP_LOAD_MULT_AND_PRODUCT     5'h0c
`define OP_LOAD_MULT_AND_SUBTRACT    5'h0d
`define OP_MULTIPLY_ACCUMULATE       5'h0e
`define OP_MULTIPLY_ACCUMULATE_MOVE  5'h0f
`define OP_LOAD_AUX_PTR              5'h10
`define OP_MULTIPLY_DATA             5'h11
`define OP_MULTIPLY_IMM              5'h12
`define OP_MULTIPLY_ADD_PREV         5'h13
`define OP_MULTIPLY_SUB_PREV         5'h14
`define OP_NORMALIZE_ACC             5'h15
`define OP_OR_IMM_SHIFT              5'h16
`define OP_OR_IMM_SHIFT16            5'h17
`define OP_PRODUCT_TO_ACC            5'h18

// Mask and match values on the first word
`define MASK_UPPER_BYTE    16'hff00
`define MASK_UPPER_5       16'hf800
`define MASK_UPPER_7       16'hfe00
`define MASK_UPPER_3       16'he000
`define MASK_UPPER_12      16'hfff0
`define MASK_UPPER_13      16'hfff8
`define MASK_FULL          16'hffff
`define PAT_LOAD_ACC_LOW_SHORT   16'hb900
`define PAT_ZERO_LOW_LOAD_HIGH   16'h6a00
`define PAT_ZERO_LOAD_LOW        16'h6900
`define PAT_LOAD_ACC_SHIFT_MULT  16'h6b00
`define PAT_LOAD_AUX_SHORT       16'hb000
`define PAT_LOAD_AUX_LONG        16'hbf08
`define PAT_LOAD_PAGE_IMM        16'hbc00
`define PAT_LOAD_STATUS_ZERO     16'h0e00
`define PAT_LOAD_STATUS_ONE      16'h0f00
`define PAT_LOAD_MULT_ACC        16'h7000
`define PAT_LOAD_MULT_ACC_MOVE   16'h7200
`define PAT_LOAD_MULT_PRODUCT    16'h7100
`define PAT_LOAD_MULT_SUBTRACT   16'h7400
`define PAT_MULT_ACC             16'ha200
`define PAT_MULT_ACC_MOVE        16'ha300
`define PAT_LOAD_AUX_PTR         16'h8b88
`define PAT_MULTIPLY_DATA        16'h5400
`define PAT_MULTIPLY_IMM         16'hc000
`define PAT_MULTIPLY_ADD_PREV    16'h5000
`define PAT_MULTIPLY_SUB_PREV    16'h5100
`define PAT_NORMALIZE_ACC        16'ha000
`define PAT_OR_IMM_SHIFT         16'hbfc0
`define PAT_OR_IMM_SHIFT16       16'hbe82
`define PAT_PRODUCT_TO_ACC       16'hbe03

// Field positions
`define FLD_ADDR_MSB    7
`define FLD_AUX_MSB     10
`define FLD_AUX_LSB     8
`define FLD_AUXP_MSB    2
`define FLD_SHIFT_MSB   3
`define FLD_PAGE_MSB    8
`define FLD_MPYK_MSB    12
`define ZERO_BYTE       8'h00

// Word and cycle counts
`define WORDS_ONE       2'h1
`define WORDS_TWO       2'h2
`define CYCLES_ONE      2'h1
`define CYCLES_TWO      2'h2
`define CYCLES_THREE    2'h3
`define SHIFT_OF_16     5'h10

`endif

// ==== verif/exec_pipe_model.sv ====
// Purpose: Execution pipeline that takes decodes, with commanded stalls
// Assumes: Stall is driven by the bench at the rising edge
// Notes: Ready lags stall by one cycle, like a registered pipe
`default_nettype none

module exec_pipe_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic dec_valid,
    output logic exec_ready,
    output logic [15:0] taken
);
    timeunit 1ns;
    timeprecision 100ps;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exec_ready <= 1'b0;
            taken <= 16'h0000;
        end else begin
            exec_ready <= !stall;
            taken <= taken + {15'h0000, dec_valid && exec_ready};
        end
    end
endmodule // exec_pipe_model
`default_nettype wire

// ==== verif/opcode_decoder_assertions.sv ====
// Purpose: Port checks on the load and multiply opcode decoder
// Assumes: One REF_CLK domain, RST asynchronous and active high
// Notes: Helper flag follows the first word of two-word forms
`default_nettype none
`include "opcode_decoder_defines.vh"

module opcode_decoder_assertions #(
    parameter WORD_WIDTH = 16
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic FETCH_VALID,
    input wire logic [WORD_WIDTH-1:0] FETCH_WORD,
    input wire logic FETCH_READY,
    input wire logic EXEC_READY,
    input wire logic DEC_VALID,
    input wire logic [4:0] DEC_OP,
    input wire logic [1:0] DEC_WORDS,
    input wire logic [1:0] DEC_CYCLES,
    input wire logic [7:0] DEC_ADDR_FIELD,
    input wire logic [WORD_WIDTH-1:0] DEC_IMM,
    input wire logic [2:0] DEC_AUX_SEL,
    input wire logic [4:0] DEC_SHIFT,
    input wire logic DEC_ZERO_ACC,
    input wire logic DEC_UNKNOWN
);
    timeunit 1ns;
    timeprecision 100ps;

    logic pend;
    logic take;
    logic first_two;
    assign take = FETCH_VALID && FETCH_READY;
    // Only the opening word of a pair counts, never its constant
    assign first_two = !pend && (FETCH_WORD[15:3] == 13'h17e1 || FETCH_WORD[15:4] == 12'hbfc
        || FETCH_WORD[15:0] == 16'hbe82 || FETCH_WORD[15:9] == 7'h51);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pend <= 1'b0;
        end else if (take) begin
            pend <= first_two;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    sequence s_one;
        take && !pend && !first_two;
    endsequence
    sequence s_mac_pair;
        take && first_two && FETCH_WORD[15:9] == 7'h51 ##1 take;
    endsequence

    a_ready_rule: assert property (FETCH_READY == (!DEC_VALID || EXEC_READY))
        else $error("fetch ready does not follow the output state");
    a_one_word_issue: assert property (s_one |=> DEC_VALID && DEC_WORDS == 2'h1
        && DEC_ADDR_FIELD == $past(FETCH_WORD[7:0]))
        else $error("one-word decode missing or wrong");
    a_pair_issue: assert property (take && pend |=> DEC_VALID && DEC_WORDS == 2'h2
        && DEC_IMM == $past(FETCH_WORD))
        else $error("two-word decode missing or wrong constant");
    a_first_silent: assert property (take && first_two && (!DEC_VALID || EXEC_READY)
        |=> !DEC_VALID)
        else $error("decode issued before constant word");
    a_hold_stall: assert property (DEC_VALID && !EXEC_READY
        |=> DEC_VALID && $stable(DEC_OP) && $stable(DEC_IMM))
        else $error("decode changed while stalled");
    a_drop_taken: assert property (DEC_VALID && EXEC_READY && !(take && !first_two)
        |=> !DEC_VALID)
        else $error("decode not released after take");
    a_short_const: assert property ((s_one and FETCH_WORD[15:8] == 8'hb9)
        |=> DEC_OP == `OP_LOAD_ACC_LOW_SHORT && DEC_IMM == {8'h00, $past(FETCH_WORD[7:0])}
        && DEC_ZERO_ACC == ($past(FETCH_WORD[7:0]) == 8'h00))
        else $error("short constant load wrong");
    a_mac_three: assert property (s_mac_pair |=> DEC_CYCLES == 2'h3
        && (DEC_OP == `OP_MULTIPLY_ACCUMULATE || DEC_OP == `OP_MULTIPLY_ACCUMULATE_MOVE))
        else $error("multiply-accumulate decode wrong");
    a_page_imm: assert property ((s_one and FETCH_WORD[15:9] == 7'h5e)
        |=> DEC_OP == `OP_LOAD_PAGE_PTR_IMM && DEC_CYCLES == 2'h2
        && DEC_IMM == {7'h00, $past(FETCH_WORD[8:0])})
        else $error("page pointer immediate wrong");
    a_reset_idle: assert property ($fell(RST) |-> !DEC_VALID && DEC_OP == 5'h00)
        else $error("decode not idle after reset");
endmodule // opcode_decoder_assertions
`default_nettype wire

// ==== verif/opcode_decoder_tb.sv ====
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Fetch side driven here, pipeline side by the model
// Notes: Every check samples at the falling edge
`default_nettype none
`include "opcode_decoder_defines.vh"

module opcode_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic REF_CLK, RST, FETCH_VALID, FETCH_READY, EXEC_READY, DEC_VALID;
    logic DEC_ZERO_ACC, DEC_UNKNOWN, stall;
    logic [15:0] FETCH_WORD, DEC_IMM, taken;
    logic [4:0] DEC_OP, DEC_SHIFT;
    logic [1:0] DEC_WORDS, DEC_CYCLES;
    logic [7:0] DEC_ADDR_FIELD;
    logic [2:0] DEC_AUX_SEL;
    int miscompares = 0;
    int n_compared = 0;
    int issued = 0;

    opcode_decoder #(.WORD_WIDTH(16)) i_opcode_decoder (.REF_CLK(REF_CLK), .RST(RST),
        .FETCH_VALID(FETCH_VALID), .FETCH_WORD(FETCH_WORD), .FETCH_READY(FETCH_READY),
        .EXEC_READY(EXEC_READY), .DEC_VALID(DEC_VALID), .DEC_OP(DEC_OP),
        .DEC_WORDS(DEC_WORDS), .DEC_CYCLES(DEC_CYCLES), .DEC_ADDR_FIELD(DEC_ADDR_FIELD),
        .DEC_IMM(DEC_IMM), .DEC_AUX_SEL(DEC_AUX_SEL), .DEC_SHIFT(DEC_SHIFT),
        .DEC_ZERO_ACC(DEC_ZERO_ACC), .DEC_UNKNOWN(DEC_UNKNOWN));
    exec_pipe_model i_exec_pipe_model (.clk(REF_CLK), .rst(RST), .stall(stall),
        .dec_valid(DEC_VALID), .exec_ready(EXEC_READY), .taken(taken));

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    task check(input logic c, input string m);
        n_compared++;
        if (c !== 1'b1) begin
            miscompares++;
            $display("[FAIL] t=%0t %s", $time, m);
        end
    endtask

    // Holds the word until an edge that sees ready high
    task send(input logic [15:0] w);
        logic ok;
        FETCH_VALID <= 1'b1;
        FETCH_WORD <= w;
        ok = 1'b0;
        while (!ok) begin
            @(negedge REF_CLK);
            ok = FETCH_READY;
            @(posedge REF_CLK);
        end
    endtask

    task await_dec;
        int k;
        k = 0;
        @(negedge REF_CLK);
        while (DEC_VALID !== 1'b1 && k < 8) begin
            @(negedge REF_CLK);
            k++;
        end
        check(DEC_VALID === 1'b1, "no decode issued");
        issued++;
    endtask

    task one(input logic [15:0] w, input logic [4:0] op, input logic [1:0] cyc,
        input logic [15:0] imm);
        send(w);
        FETCH_VALID <= 1'b0;
        await_dec();
        check(DEC_OP === op && DEC_WORDS === 2'h1 && DEC_CYCLES === cyc, "op or counts");
        check(DEC_IMM === imm && DEC_ADDR_FIELD === w[7:0], "operand fields");
        check(DEC_UNKNOWN === (op === 5'h00) && DEC_ZERO_ACC === (w === 16'hb900), "flags");
        if (op === 5'h05 || op === 5'h10) begin
            check(DEC_AUX_SEL === (w[13] ? w[10:8] : w[2:0]), "aux select");
        end
        @(posedge REF_CLK);
    endtask

    task two(input logic [15:0] w1, input logic [15:0] w2, input logic [4:0] op,
        input logic [1:0] cyc, input logic [4:0] sh);
        send(w1);
        send(w2);
        FETCH_VALID <= 1'b0;
        await_dec();
        check(DEC_OP === op && DEC_WORDS === 2'h2 && DEC_CYCLES === cyc, "pair counts");
        check(DEC_IMM === w2, "constant word");
        if (op === 5'h16 || op === 5'h17) begin
            check(DEC_SHIFT === sh, "shift field");
        end
        if (op === 5'h06) begin
            check(DEC_AUX_SEL === w1[2:0], "long aux select");
        end
        @(posedge REF_CLK);
    endtask

    task t_reset;
        @(negedge REF_CLK);
        check(DEC_VALID === 1'b0 && FETCH_READY === 1'b1 && DEC_OP === 5'h00, "reset state");
        @(posedge REF_CLK);
        $display("t_reset done");
    endtask

    task t_one_word;
        one(16'hb905, 5'h01, 2'h1, 16'h0005);
        one(16'hb900, 5'h01, 2'h1, 16'h0000);
        one(16'h6a12, 5'h02, 2'h1, 16'h0000);
        one(16'h6934, 5'h03, 2'h1, 16'h0000);
        one(16'h6b56, 5'h04, 2'h1, 16'h0000);
        one(16'hb7ab, 5'h05, 2'h2, 16'h00ab);
        one(16'hbd23, 5'h07, 2'h2, 16'h0123);
        one(16'h0e11, 5'h08, 2'h2, 16'h0000);
        one(16'h0f22, 5'h09, 2'h2, 16'h0000);
        one(16'h7033, 5'h0a, 2'h1, 16'h0000);
        one(16'h7244, 5'h0b, 2'h1, 16'h0000);
        one(16'h7155, 5'h0c, 2'h1, 16'h0000);
        one(16'h7466, 5'h0d, 2'h1, 16'h0000);
        one(16'h8b8d, 5'h10, 2'h1, 16'h0000);
        one(16'h5477, 5'h11, 2'h1, 16'h0000);
        one(16'hdfff, 5'h12, 2'h1, 16'h1fff);
        one(16'h5088, 5'h13, 2'h1, 16'h0000);
        one(16'h5199, 5'h14, 2'h1, 16'h0000);
        one(16'ha0aa, 5'h15, 2'h1, 16'h0000);
        one(16'hbe03, 5'h18, 2'h1, 16'h0000);
        one(16'h1234, 5'h00, 2'h1, 16'h0000);
        one(16'hbf07, 5'h00, 2'h1, 16'h0000);
        $display("t_one_word done");
    endtask

    task t_two_word;
        two(16'hbf0d, 16'h1357, 5'h06, 2'h2, 5'h00);
        two(16'hbfc0, 16'ha5a5, 5'h16, 2'h2, 5'h00);
        two(16'hbfcf, 16'h5a5a, 5'h16, 2'h2, 5'h0f);
        two(16'hbe82, 16'h0f0f, 5'h17, 2'h2, 5'h10);
        two(16'ha255, 16'hb905, 5'h0e, 2'h3, 5'h00);
        two(16'ha3aa, 16'hffff, 5'h0f, 2'h3, 5'h00);
        $display("t_two_word done");
    endtask

    // Pipeline refuses; the decode must stand and fetch must stall
    task t_stall;
        stall <= 1'b1;
        send(16'h7055);
        FETCH_WORD <= 16'h5088;
        repeat (4) begin
            @(negedge REF_CLK);
            check(DEC_VALID === 1'b1 && !FETCH_READY && DEC_OP === 5'h0a, "held");
        end
        issued++;
        @(posedge REF_CLK);
        stall <= 1'b0;
        send(16'h5088);
        FETCH_VALID <= 1'b0;
        await_dec();
        check(DEC_OP === 5'h13, "decode after stall");
        @(posedge REF_CLK);
        @(negedge REF_CLK);
        check(taken === 16'(issued), "pipeline take count");
        $display("t_stall done");
    endtask

    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        RST = 1'b1;
        FETCH_VALID = 1'b0;
        FETCH_WORD = 16'h0000;
        stall = 1'b0;
        repeat (6) @(posedge REF_CLK);
        RST <= 1'b0;
        t_reset();
        t_one_word();
        t_two_word();
        t_stall();
        finish_test();
    end

    // Whole run is under a hundred cycles
    initial begin
        #100us;
        miscompares++;
        finish_test();
    end
endmodule // opcode_decoder_tb

bind opcode_decoder opcode_decoder_assertions #(.WORD_WIDTH(WORD_WIDTH)) i_assert (
    .REF_CLK(REF_CLK), .RST(RST), .FETCH_VALID(FETCH_VALID), .FETCH_WORD(FETCH_WORD),
    .FETCH_READY(FETCH_READY), .EXEC_READY(EXEC_READY), .DEC_VALID(DEC_VALID),
    .DEC_OP(DEC_OP), .DEC_WORDS(DEC_WORDS), .DEC_CYCLES(DEC_CYCLES),
    .DEC_ADDR_FIELD(DEC_ADDR_FIELD), .DEC_IMM(DEC_IMM), .DEC_AUX_SEL(DEC_AUX_SEL),
    .DEC_SHIFT(DEC_SHIFT), .DEC_ZERO_ACC(DEC_ZERO_ACC), .DEC_UNKNOWN(DEC_UNKNOWN));
`default_nettype wire
